// file: design/dhi_pkg.sv
// Purpose: Shared constants and types for the display host interface link.
// Assumes: Strap codes, opcodes and pixel formats as used by both ends.
// Notes:   Timing counts derive from the 25 MHz aclk rate.
package dhi_pkg;

  // ----------------------------------------------------------------------
  // Interface select strap codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] STRAP_SERIAL   = 4'h5;
  localparam logic [3:0] STRAP_PARALLEL = 4'h2;

  // ----------------------------------------------------------------------
  // Command opcodes and pixel format codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_PIXEL_FORMAT = 8'h3a;
  localparam logic [7:0] OP_MEM_WRITE    = 8'h2c;
  localparam logic [7:0] OP_SLEEP_EXIT   = 8'h11;
  localparam logic [2:0] FMT_RGB16       = 3'h5;
  localparam logic [2:0] FMT_RGB18       = 3'h6;
  localparam logic [2:0] FMT_RESET       = 3'h6;
  localparam int         FMT_LSB         = 4;

  // ----------------------------------------------------------------------
  // Geometry and widths
  // ----------------------------------------------------------------------
  localparam int PIX_W  = 18;
  localparam int ADDR_W = 10;
  localparam int MEM_WORDS = 1024;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ         = 25;
  localparam int CMD_WAIT_MS     = 5;
  localparam int SLEEP_WAIT_MS   = 120;
  localparam int CMD_WAIT_CYC    = CMD_WAIT_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_WAIT_CYC  = SLEEP_WAIT_MS * 1000 * CLK_MHZ;
  localparam int SCL_DIV         = 2;

  // ----------------------------------------------------------------------
  // Register map of the host controller (AXI4-Lite byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam int CMD_DC_BIT = 8;
  localparam int CMD_GO_BIT = 9;

endpackage

// file: design/dhi_if.sv
// Purpose: Carrier for the serial and RGB pins between host and display.
// Assumes: The host makes the serial clock; the display end samples pins.
// Notes:   Serial data is one-way host to display here.
`timescale 1ns/1ns
interface dhi_if;
  logic [3:0]  interface_select_straps;
  logic        chip_select_n;
  logic        serial_clk;
  logic        serial_din;
  logic        cmd_data_line;
  logic        write_strobe_n;
  logic        read_strobe_n;
  logic [15:0] par_data;
  logic        pixel_clock;
  logic        frame_sync;
  logic        line_sync;
  logic        data_enable;
  logic [17:0] pixel_data_bus;

  modport host (output interface_select_straps, chip_select_n, serial_clk, serial_din,
                cmd_data_line, write_strobe_n, read_strobe_n, par_data, pixel_clock,
                frame_sync, line_sync, data_enable, pixel_data_bus);
  modport dev  (input interface_select_straps, chip_select_n, serial_clk, serial_din,
                cmd_data_line, write_strobe_n, read_strobe_n, par_data, pixel_clock,
                frame_sync, line_sync, data_enable, pixel_data_bus);
endinterface

// file: design/dhi_display.sv
// How it works
// [R1] Straps 0101 select the serial host port.
// [R2] Packet is select bit then one byte.
// [R3] Select low: byte is a command opcode.
// [R4] Select high: memory write or command parameter.
// [R5] Straps 0010 select 16-bit parallel bus. Here they only raise parallel_active; par_data and the strobes are never read.
// [R6] RGB mode samples syncs, enable, data.
// [R7] Opcode 3Ah sets the pixel format field.
// [R8] Format 101: 16-bit RGB, lines 15:0.
// [R9] Format 110: 18-bit RGB, all lines.
// [R10] Host programs only format 101 or 110.
// [R11] RGB refresh timed by host syncs.
// [R12] RGB pixels written only while enabled.
// [R13] Host waits 5 ms, 120 ms before sleep exit.
//
// Purpose: Display end: decodes host packets and writes frame memory.
// Assumes: Serial clock and pixel clock come from the host.
// Notes:   Frame memory is a small model array; sizes are fixed.
`timescale 1ns/1ns
module dhi_display (
  input  wire logic                   pixel_clock,
  input  wire logic                   serial_clk,
  input  wire logic                   hw_reset_n,
  dhi_if.dev                          pins,
  input  wire logic                   rgb_mode,
  output logic                        serial_active,
  output logic                        parallel_active,
  output logic [2:0]                  pixel_format_field,
  output logic [7:0]                  last_cmd,
  output logic [dhi_pkg::ADDR_W-1:0]  write_addr,
  output logic [dhi_pkg::PIX_W-1:0]   last_pixel,
  output logic [9:0]                  line_count
);

  // ----------------------------------------------------------------------
  // Strap decode on the pixel clock
  // ----------------------------------------------------------------------
  logic [3:0] strap_s1_r;
  logic [3:0] strap_r;
  logic       sleep_out_r;

  // Straps pass two flops on the free pixel clock; the serial clock stops
  // between packets and would leave a strap change unseen.
  always_ff @(posedge pixel_clock)
  begin
    strap_s1_r <= pins.interface_select_straps;
    strap_r    <= strap_s1_r;
  end

  // Commands still arrive serially while the RGB pins carry pixels.
  assign serial_active   = (strap_r == dhi_pkg::STRAP_SERIAL);                // [R1]
  assign parallel_active = (strap_r == dhi_pkg::STRAP_PARALLEL);              // [R5]

  // ----------------------------------------------------------------------
  // Serial packet shifter: one select bit then eight data bits
  // ----------------------------------------------------------------------
  logic [3:0] bit_cnt_r;
  logic       dc_r;
  logic [7:0] shift_r;
  logic       pkt_done;
  logic [7:0] pkt_byte;

  assign pkt_byte = {shift_r[6:0], pins.serial_din};
  assign pkt_done = serial_active && !pins.chip_select_n && (bit_cnt_r == 4'h8);

  // Chip select high aborts a partial packet so framing always restarts.
  always_ff @(posedge serial_clk)
  begin
    if (!hw_reset_n || pins.chip_select_n)
      bit_cnt_r <= 4'h0;
    else if (pkt_done)
      bit_cnt_r <= 4'h0;                                                      // [R2]
    else
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  // The first bit of a packet is the select, the next eight the byte.
  always_ff @(posedge serial_clk)
  begin
    if (!hw_reset_n)
    begin
      dc_r    <= 1'b0;
      shift_r <= 8'h00;
    end
    else if (!pins.chip_select_n)
    begin
      if (bit_cnt_r == 4'h0)
        dc_r <= pins.serial_din;                                              // [R2]
      else
        shift_r <= pkt_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Command decode and parameter capture
  // ----------------------------------------------------------------------
  logic [7:0]                 cmd_r;
  logic [2:0]                 fmt_r;
  logic                       mem_wr_r;
  logic [dhi_pkg::ADDR_W-1:0] ser_addr_r;

  always_ff @(posedge serial_clk)
  begin
    if (!hw_reset_n)
    begin
      cmd_r       <= 8'h00;
      fmt_r       <= dhi_pkg::FMT_RESET;
      mem_wr_r    <= 1'b0;
      ser_addr_r  <= '0;
      sleep_out_r <= 1'b0;
    end
    else if (pkt_done && !dc_r)
    begin
      cmd_r      <= pkt_byte;                                                 // [R3]
      mem_wr_r   <= (pkt_byte == dhi_pkg::OP_MEM_WRITE);
      ser_addr_r <= '0;
      if (pkt_byte == dhi_pkg::OP_SLEEP_EXIT)
        sleep_out_r <= 1'b1;
    end
    else if (pkt_done && dc_r)
    begin
      if (mem_wr_r)
        ser_addr_r <= ser_addr_r + 1'b1;                                      // [R4]
      else if (cmd_r == dhi_pkg::OP_PIXEL_FORMAT)
        fmt_r <= pkt_byte[dhi_pkg::FMT_LSB +: 3];                             // [R7] [R4]
    end
  end

  assign last_cmd = cmd_r;

  // ----------------------------------------------------------------------
  // Format crosses to the pixel clock through two flops
  // ----------------------------------------------------------------------
  logic [2:0] fmt_s1_r;
  logic [2:0] fmt_s2_r;
  always_ff @(posedge pixel_clock)
  begin
    fmt_s1_r <= fmt_r;
    fmt_s2_r <= fmt_s1_r;
  end
  // Field is quasi-static; the host changes it only while no frame runs.
  assign pixel_format_field = fmt_s2_r;

  // ----------------------------------------------------------------------
  // Frame memory
  // ----------------------------------------------------------------------
  logic [dhi_pkg::PIX_W-1:0] frame_memory [dhi_pkg::MEM_WORDS];

  // Serial memory writes only advance the address; the array has one writer.
  // ----------------------------------------------------------------------
  // RGB path: refresh timed by host syncs, writes gated by enable
  // ----------------------------------------------------------------------
  logic [dhi_pkg::ADDR_W-1:0] rgb_addr_r;
  logic [dhi_pkg::PIX_W-1:0]  pix_r;
  logic [9:0]                 line_r;
  logic                       line_sync_d_r;
  logic [dhi_pkg::PIX_W-1:0]  pix_word;

  // Format 101 uses lines 15:0 only; 110 uses all eighteen.
  always_comb
  begin
    if (fmt_s2_r == dhi_pkg::FMT_RGB16)
      pix_word = {2'b00, pins.pixel_data_bus[15:0]};                          // [R8]
    else
      pix_word = pins.pixel_data_bus;                                         // [R9] [R10]
  end

  always_ff @(posedge pixel_clock)
  begin
    if (!hw_reset_n || pins.frame_sync)
    begin
      rgb_addr_r    <= '0;                                                    // [R11]
      line_r        <= 10'h000;
      line_sync_d_r <= 1'b0;
      pix_r         <= '0;
    end
    else if (rgb_mode)
    begin
      line_sync_d_r <= pins.line_sync;                                        // [R6]
      if (pins.line_sync && !line_sync_d_r)
        line_r <= line_r + 10'h001;                                           // [R11]
      if (pins.data_enable)
      begin
        frame_memory[rgb_addr_r] <= pix_word;                                 // [R12]
        rgb_addr_r <= rgb_addr_r + 1'b1;
        pix_r      <= pix_word;
      end
    end
  end

  assign write_addr = rgb_mode ? rgb_addr_r : ser_addr_r;
  assign last_pixel = pix_r;
  assign line_count = line_r;

endmodule

// file: design/dhi_host.sv
// Purpose: Host end: sends serial packets and drives the RGB pins.
// Assumes: AXI4-Lite orders; the serial clock is divided from aclk.
// Notes:   One packet at a time; RGB pins are fed from user ports.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module dhi_host #(
  parameter int CMD_WAIT   = dhi_pkg::CMD_WAIT_CYC,
  parameter int SLEEP_WAIT = dhi_pkg::SLEEP_WAIT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  dhi_if.host              pins,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        pixel_clock_in,
  input  wire logic        frame_sync_in,
  input  wire logic        line_sync_in,
  input  wire logic        data_enable_in,
  input  wire logic [17:0] pixel_data_in
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } ser_state_t;

  // ----------------------------------------------------------------------
  // Reset wait counter: no command until 5 ms, no sleep exit until 120 ms
  // ----------------------------------------------------------------------
  logic [31:0] wait_cnt_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wait_cnt_r <= 32'h0000_0000;
    else if (wait_cnt_r < 32'(SLEEP_WAIT))
      wait_cnt_r <= wait_cnt_r + 32'h0000_0001;                               // [R13]
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------------
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_r;
  logic [31:0] wd_r;
  logic        go_r;
  logic [8:0]  pkt_r;
  logic [3:0]  straps_r;
  logic        busy_r;

  assign s_awready = !aw_got_r && !s_bvalid;
  assign s_wready  = !w_got_r && !s_bvalid;
  assign s_bresp   = 2'b00;

  // Address and data are taken in either order; response follows both.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_r     <= 8'h00;
      wd_r     <= 32'h0000_0000;
      s_bvalid <= 1'b0;
      go_r     <= 1'b0;
      pkt_r    <= 9'h000;
      straps_r <= dhi_pkg::STRAP_SERIAL;
    end
    else
    begin
      go_r <= 1'b0;
      if (s_awvalid && s_awready)
      begin
        aw_got_r <= 1'b1;
        aw_r     <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_r <= 1'b1;
        wd_r    <= s_wdata;
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        s_bvalid <= 1'b1;
        if (aw_r == dhi_pkg::REG_CMD && !busy_r)
        begin
          pkt_r <= {wd_r[dhi_pkg::CMD_DC_BIT], wd_r[7:0]};
          go_r  <= wd_r[dhi_pkg::CMD_GO_BIT];
        end
        else if (aw_r == dhi_pkg::REG_CTRL)
          straps_r <= wd_r[3:0];
      end
      if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read side: status shows busy and the wait windows
  // ----------------------------------------------------------------------
  logic cmd_ok;
  logic sleep_ok;
  assign cmd_ok    = wait_cnt_r >= 32'(CMD_WAIT);
  assign sleep_ok  = wait_cnt_r >= 32'(SLEEP_WAIT);
  assign s_arready = !s_rvalid;
  assign s_rresp   = 2'b00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      unique case (s_araddr)
        dhi_pkg::REG_STATUS: s_rdata <= {29'h0, sleep_ok, cmd_ok, busy_r};
        dhi_pkg::REG_CTRL:   s_rdata <= {28'h0, straps_r};
        dhi_pkg::REG_CMD:    s_rdata <= {23'h0, pkt_r};
        default:             s_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_rvalid && s_rready)
      s_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Serial sender: select bit first, then byte MSB first
  // ----------------------------------------------------------------------
  ser_state_t state_r;
  logic [3:0] bit_r;
  logic       sleep_hold;

  // A sleep-exit opcode before 120 ms, or anything before 5 ms, is held.
  assign sleep_hold = !cmd_ok ||
                      (!pkt_r[8] && pkt_r[7:0] == dhi_pkg::OP_SLEEP_EXIT && !sleep_ok);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      bit_r   <= 4'h0;
      busy_r  <= 1'b0;
    end
    else
    begin
      if (go_r)
        busy_r <= 1'b1;
      unique case (state_r)
        ST_IDLE:
          if (busy_r && !sleep_hold)                                          // [R13]
          begin
            state_r <= ST_LOW;
            bit_r   <= 4'h0;
          end
        ST_LOW:
          state_r <= ST_HIGH;
        ST_HIGH:
          if (bit_r == 4'h8)                                                  // [R2]
          begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
          end
          else
          begin
            state_r <= ST_LOW;
            bit_r   <= bit_r + 4'h1;
          end
      endcase
    end
  end

  // Pins: straps, serial clock divided from aclk, select bit leads.
  assign pins.interface_select_straps = straps_r;                             // [R1] [R5]
  assign pins.chip_select_n  = (state_r == ST_IDLE);
  assign pins.serial_clk     = (state_r == ST_HIGH);
  assign pins.serial_din     = pkt_r[4'h8 - bit_r];                           // [R2]
  assign pins.cmd_data_line  = pkt_r[8];
  assign pins.write_strobe_n = 1'b1;
  assign pins.read_strobe_n  = 1'b1;
  assign pins.par_data       = 16'h0000;
  // RGB pins pass straight from the pixel source; the host owns timing.
  assign pins.pixel_clock    = pixel_clock_in;                                // [R6]
  assign pins.frame_sync     = frame_sync_in;
  assign pins.line_sync      = line_sync_in;
  assign pins.data_enable    = data_enable_in;
  assign pins.pixel_data_bus = pixel_data_in;

endmodule

// file: tb/dhi_assertions.sv
// Purpose: Concurrent checks on the serial pins between host and display.
// Assumes: Serial clock is made from aclk; one bit takes two aclk cycles.
// Notes:   Pixel pins only mirror host inputs, so the bench judges them.
`timescale 1ns/1ns
module dhi_assertions (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [3:0] interface_select_straps,
  input wire logic       chip_select_n,
  input wire logic       serial_clk,
  input wire logic       serial_din,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n
);
  logic [3:0] bits_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // --------------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------------
  // Counts serial clock rises inside one frame, so framing can be judged.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || chip_select_n)
      bits_r <= 4'h0;
    else if ($rose(serial_clk))
      bits_r <= bits_r + 4'h1;
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_reset_idle_pins: assert property ($rose(aresetn) |-> chip_select_n && !serial_clk)
    else $error("serial pins not idle after reset");
  a_idle_clock_low: assert property (chip_select_n |-> !serial_clk)
    else $error("serial clock moves outside a frame");
  a_clock_high_one: assert property ($rose(serial_clk) |=> $fell(serial_clk))
    else $error("serial clock high longer than one cycle");
  a_clock_low_one: assert property ($fell(serial_clk) && bits_r < 4'h9 |=> serial_clk)
    else $error("serial clock low too long inside a frame");
  a_nine_bits_frame: assert property ($rose(chip_select_n) |-> bits_r == 4'h9)
    else $error("frame does not hold nine bits");
  a_frame_length: assert property ($fell(chip_select_n) |-> ##[17:30] $rose(chip_select_n))
    else $error("frame length out of range");
  a_data_stable_high: assert property (serial_clk |-> $stable(serial_din))
    else $error("serial data changed at clock rise");
  a_strap_hold: assert property (!chip_select_n |-> $stable(interface_select_straps))
    else $error("straps changed inside a frame");
  a_parallel_quiet: assert property
    (interface_select_straps == dhi_pkg::STRAP_SERIAL |-> write_strobe_n && read_strobe_n)
    else $error("parallel strobes active in serial mode");
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench joining host and display ends.
// Assumes: Wait counts shortened to 20 and 40 aclk cycles.
// Notes:   Pixel clock runs free so the display pixel logic can reset.
`timescale 1ns/1ns
module testbench;
  logic        aclk = 1'b0;
  logic        pclk = 1'b0;
  logic        aresetn, hw_reset_n, rgb_mode, fs, ls, de;
  logic [17:0] pix_d;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic        serial_active, parallel_active;
  logic [2:0]  pixel_format_field;
  logic [7:0]  last_cmd;
  logic [9:0]  write_addr, line_count;
  logic [17:0] last_pixel;
  logic [8:0]  cap_r;
  int          mismatches = 0;
  int          n_compared = 0;

  // --------------------------------------------------------------------
  // Clocks, ends and checker
  // --------------------------------------------------------------------
  // The pixel clock starts off phase so the two domains never align.
  always #20 aclk = ~aclk;
  initial #7 forever #15 pclk = ~pclk;

  dhi_if dhi_if_inst ();
  dhi_host #(.CMD_WAIT(20), .SLEEP_WAIT(40)) dhi_host_inst (
    .aclk(aclk), .aresetn(aresetn), .pins(dhi_if_inst),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .pixel_clock_in(pclk), .frame_sync_in(fs), .line_sync_in(ls),
    .data_enable_in(de), .pixel_data_in(pix_d));
  dhi_display dhi_display_inst (
    .pixel_clock(dhi_if_inst.pixel_clock), .serial_clk(dhi_if_inst.serial_clk),
    .hw_reset_n(hw_reset_n), .pins(dhi_if_inst), .rgb_mode(rgb_mode),
    .serial_active(serial_active), .parallel_active(parallel_active),
    .pixel_format_field(pixel_format_field), .last_cmd(last_cmd),
    .write_addr(write_addr), .last_pixel(last_pixel), .line_count(line_count));
  dhi_assertions dhi_assertions_inst (
    .aclk(aclk), .aresetn(aresetn),
    .interface_select_straps(dhi_if_inst.interface_select_straps),
    .chip_select_n(dhi_if_inst.chip_select_n), .serial_clk(dhi_if_inst.serial_clk),
    .serial_din(dhi_if_inst.serial_din), .write_strobe_n(dhi_if_inst.write_strobe_n),
    .read_strobe_n(dhi_if_inst.read_strobe_n));

  // The bench's own capture of the wire, MSB first, for framing checks.
  always @(posedge dhi_if_inst.serial_clk)
    if (dhi_if_inst.chip_select_n === 1'b0)
      cap_r <= {cap_r[7:0], dhi_if_inst.serial_din};

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wvalid <= 1'b1; s_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) break;
    end
    s_bready <= 1'b0;
    if (n == 40) timeout();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) break;
    end
    d = s_rdata;
    s_rready <= 1'b0;
    if (n == 40) timeout();
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    for (n = 0; n < 60; n++)
    begin
      axr(dhi_pkg::REG_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 60) timeout();
  endtask

  // Sends one packet and compares the nine bits seen on the wire.
  task automatic send(input logic dc, input logic [7:0] b);
    axw(dhi_pkg::REG_CMD, {22'h0, 1'b1, dc, b});
    wait_idle();
    check(32'(cap_r), 32'({dc, b}));
  endtask

  task automatic pix(input logic f, input logic l, input logic e, input logic [17:0] d);
    @(posedge pclk);
    fs <= f; ls <= l; de <= e; pix_d <= d;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Sleep exit is held back until the long window, also past the short one.
  task automatic t_wait();
    logic [31:0] s;
    axw(dhi_pkg::REG_CMD, {22'h0, 2'b10, dhi_pkg::OP_SLEEP_EXIT});
    axr(dhi_pkg::REG_STATUS, s);
    check(32'(s[2:0]), 32'h0000_0001);
    repeat (20) @(posedge aclk);
    check(32'(dhi_if_inst.chip_select_n), 32'h0000_0001);
    axr(dhi_pkg::REG_STATUS, s);
    check(32'(s[2:0]), 32'h0000_0003);
    wait_idle();
    check(32'(cap_r), 32'({1'b0, dhi_pkg::OP_SLEEP_EXIT}));
    @(posedge aclk);
    hw_reset_n <= 1'b1;
    $display("test wait done");
  endtask

  task automatic t_straps();
    logic [31:0] d;
    axr(dhi_pkg::REG_CTRL, d);
    check(32'(d[3:0]), 32'(dhi_pkg::STRAP_SERIAL));
    check(32'({serial_active, parallel_active}), 32'h0000_0002);
    axw(dhi_pkg::REG_CTRL, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    check(32'(dhi_if_inst.interface_select_straps), 32'(dhi_pkg::STRAP_PARALLEL));
    check(32'({serial_active, parallel_active}), 32'h0000_0001);
    axw(dhi_pkg::REG_CTRL, 32'h0000_0005);
    $display("test straps done");
  endtask

  task automatic t_cmd();
    logic [9:0] a0;
    check(32'(pixel_format_field), 32'(dhi_pkg::FMT_RESET));
    send(1'b0, dhi_pkg::OP_MEM_WRITE);
    check(32'(last_cmd), 32'(dhi_pkg::OP_MEM_WRITE));
    a0 = write_addr;
    send(1'b1, 8'ha5);
    check(32'(write_addr), 32'(a0 + 10'h001));
    check(32'(last_cmd), 32'(dhi_pkg::OP_MEM_WRITE));
    send(1'b0, dhi_pkg::OP_PIXEL_FORMAT);
    send(1'b1, 8'h55);
    check(32'(pixel_format_field), 32'(dhi_pkg::FMT_RGB16));
    // A second order while busy must be dropped whole.
    axw(dhi_pkg::REG_CMD, {22'h0, 2'b10, dhi_pkg::OP_MEM_WRITE});
    axw(dhi_pkg::REG_CMD, {22'h0, 2'b10, dhi_pkg::OP_PIXEL_FORMAT});
    wait_idle();
    check(32'(last_cmd), 32'(dhi_pkg::OP_MEM_WRITE));
    $display("test commands done");
  endtask

  task automatic t_rgb();
    send(1'b0, dhi_pkg::OP_PIXEL_FORMAT);
    send(1'b1, 8'h66);
    check(32'(pixel_format_field), 32'(dhi_pkg::FMT_RGB18));
    rgb_mode <= 1'b1;
    pix(1'b1, 1'b0, 1'b0, 18'h0_0000);
    pix(1'b0, 1'b0, 1'b0, 18'h0_0000);
    repeat (3)
    begin
      pix(1'b0, 1'b1, 1'b0, 18'h0_0000);
      pix(1'b0, 1'b0, 1'b0, 18'h0_0000);
    end
    pix(1'b0, 1'b0, 1'b1, 18'h2_a5c3);
    pix(1'b0, 1'b0, 1'b0, 18'h1_0f0f);
    repeat (4) pix(1'b0, 1'b0, 1'b0, 18'h0_0000);
    check(32'(last_pixel), 32'h0002_a5c3);
    check(32'(line_count), 32'h0000_0003);
    send(1'b0, dhi_pkg::OP_PIXEL_FORMAT);
    send(1'b1, 8'h55);
    pix(1'b0, 1'b0, 1'b1, 18'h3_1234);
    repeat (4) pix(1'b0, 1'b0, 1'b0, 18'h0_0000);
    check(32'(last_pixel), 32'h0000_1234);
    $display("test rgb done");
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  // Display reset stays low through the first packet, whose serial edges
  // are the only ones that can clear the display's serial logic.
  initial
  begin
    aresetn = 1'b0; hw_reset_n = 1'b0; rgb_mode = 1'b0;
    fs = 1'b0; ls = 1'b0; de = 1'b0; pix_d = 18'h0_0000; cap_r = 9'h000;
    s_awaddr = 8'h00; s_awvalid = 1'b0; s_wdata = 32'h0000_0000; s_wstrb = 4'hf;
    s_wvalid = 1'b0; s_bready = 1'b0; s_araddr = 8'h00; s_arvalid = 1'b0; s_rready = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_wait();
    t_straps();
    t_cmd();
    t_rgb();
    print_verdict();
  end
endmodule
